//--- design/cdio_top.sv
// Top of the digital I/O block: APB register slave, two parallel
// interface units, change-of-state interrupt, host window decode and
// interrupt level routing.
// Assumes a 32-bit APB master on pclk and line inputs synchronous to it.
//
// Design decisions made here: the placing of the registers and register access over APB.

// What this block does
// - Input changes set a latched interrupt request.
// - Six enable bits gate each port's detection.
// - Request holds until software write clears it.
// - Two units, three byte ports each.
// - Each port input or latched output.
// - Third port splits into nibble halves.
// - Buffer direction follows unit direction control.
// - Flag set lets software switch buffers.
// - Decode 32-byte window, base 100 to 3E0.
// - Interrupt routed to one legal host level.
// - Five negative-true jumpers give address bits 5-9.
module cdio_top (
  input wire logic pclk,                    // Clock, 50 MHz.
  input wire logic presetn,                 // Asynchronous reset, active low.
  input wire logic psel,                    // APB select.
  input wire logic penable,                 // APB enable.
  input wire logic pwrite,                  // APB direction.
  input wire logic [7:0] paddr,             // APB byte address.
  input wire logic [31:0] pwdata,           // APB write data.
  output logic [31:0] prdata,               // APB read data.
  output logic pready,                      // APB ready.
  output logic pslverr,                     // APB error, unmapped address.
  input wire logic [47:0] io_in,            // Line levels.
  output logic [47:0] io_out,               // Line drive values.
  output logic [47:0] io_oe_n,              // Line driver enable, low drives.
  input wire logic [4:0] addr_jumper_on,    // Address jumpers A5..A9, 1 installed.
  input wire logic [9:0] host_io_addr,      // Host I/O address.
  output logic host_win_hit,                // Host address falls in window.
  output logic irq,                         // Interrupt, high while pending.
  output logic [15:0] host_irq_lines        // Routed interrupt request levels.
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [5:0] irq_en_r;
  logic [5:0] irq_st_r;
  logic [5:0] irq_st_nxt;
  logic [2:0] buf_r;
  logic [3:0] irq_lvl_r;
  logic [4:0] base_r;
  logic base_cap_r;
  logic irq_r;
  logic [15:0] irq_lines_r;
  logic win_hit_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup_ph = psel && !penable && !pready_r;
  wire wr_acc = psel && penable && pready_r && pwrite;
  wire [7:0] ofs_in_unit = paddr & 8'h0F;
  wire unit_sel1 = (paddr & 8'hF0) == cdio_pkg::OFS_UNIT_STRIDE;
  wire unit_hit = (paddr & 8'hE0) == 8'h00;
  wire hit_en = paddr == cdio_pkg::OFS_IRQ_EN;
  wire hit_st = paddr == cdio_pkg::OFS_IRQ_ST;
  wire hit_buf = paddr == cdio_pkg::OFS_BUF;
  wire hit_lvl = paddr == cdio_pkg::OFS_IRQ_LVL;
  wire hit_base = paddr == cdio_pkg::OFS_BASE;
  wire addr_ok = ((unit_hit && paddr[1:0] == 2'h0) || hit_en || hit_st || hit_buf || hit_lvl
                  || hit_base);
  wire [1:0] unit_reg = ofs_in_unit[3:2];

  // ----------------------------------------------------------------
  // Parallel interface units
  // ----------------------------------------------------------------
  logic [23:0] port_rd [2];
  logic [3:0] ctrl_rd [2];
  logic [5:0] chg;
  logic [1:0] buf_on;

  genvar u;
  generate
    for (u = 0; u < cdio_pkg::NUM_UNITS; u++) begin : g_unit
      wire unit_wr = wr_acc && unit_hit && paddr[1:0] == 2'h0 && (unit_sel1 == (u == 1));
      // Buffers stay on unless the program-control flag hands them to software.
      assign buf_on[u] = !buf_r[cdio_pkg::BUF_PROG] || buf_r[cdio_pkg::BUF_EN0 + u];
      cdio_unit u_unit (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(unit_wr),
        .wr_sel(unit_reg),
        .wdata(pwdata[7:0]),
        .buf_on(buf_on[u]),
        .pin_in(io_in[u*24 +: 24]),
        .pin_out(io_out[u*24 +: 24]),
        .pin_oe_n(io_oe_n[u*24 +: 24]),
        .port_rd(port_rd[u]),
        .ctrl_rd(ctrl_rd[u]),
        .chg(chg[u*3 +: 3])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [23:0] sel_port = unit_sel1 ? port_rd[1] : port_rd[0];
  wire [3:0] sel_ctrl = unit_sel1 ? ctrl_rd[1] : ctrl_rd[0];
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (unit_hit) begin
      case (unit_reg)
        2'h0: rd_mux = {24'h00_0000, sel_port[7:0]};
        2'h1: rd_mux = {24'h00_0000, sel_port[15:8]};
        2'h2: rd_mux = {24'h00_0000, sel_port[23:16]};
        default: rd_mux = {28'h000_0000, sel_ctrl};
      endcase
    end else if (hit_en) begin
      rd_mux = {26'h000_0000, irq_en_r};
    end else if (hit_st) begin
      rd_mux = {26'h000_0000, irq_st_r};
    end else if (hit_buf) begin
      rd_mux = {29'h000_0000, buf_r};
    end else if (hit_lvl) begin
      rd_mux = {28'h000_0000, irq_lvl_r};
    end else if (hit_base) begin
      rd_mux = {27'h000_0000, base_r};
    end
  end

  // ----------------------------------------------------------------
  // APB response: no wait state, answer in the first access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph && !addr_ok;
      prdata_r <= (setup_ph && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  wire [3:0] lvl_wr = pwdata[3:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= cdio_pkg::IRQ_EN_RST;
      buf_r <= cdio_pkg::BUF_RST;
      irq_lvl_r <= cdio_pkg::IRQ_LVL_RST;
    end else begin
      if (wr_acc && hit_en) begin
        irq_en_r <= pwdata[5:0];
      end
      if (wr_acc && hit_buf) begin
        buf_r <= pwdata[2:0];
      end
      // Only a legal host level is accepted, so exactly one stays selected.
      if (wr_acc && hit_lvl && cdio_pkg::IRQ_LEGAL[lvl_wr]) begin
        irq_lvl_r <= lvl_wr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Change-of-state latch
  // ----------------------------------------------------------------
  wire [5:0] st_set = chg & irq_en_r;
  wire [5:0] st_clr = (wr_acc && hit_st) ? pwdata[5:0] : 6'h00;

  // A new change in the cycle of a clear keeps the bit set.
  assign irq_st_nxt = (irq_st_r & ~st_clr) | st_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= 6'h00;
      irq_r <= 1'b0;
      irq_lines_r <= 16'h0000;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_r <= |irq_st_nxt;
      irq_lines_r <= (|irq_st_nxt) ? (16'h0001 << irq_lvl_r) : 16'h0000;
    end
  end

  assign irq = irq_r;
  assign host_irq_lines = irq_lines_r;

  // ----------------------------------------------------------------
  // Base address jumpers and host window decode
  // ----------------------------------------------------------------
  // The jumpers are sampled once, in the first cycle after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= 5'h1F;
      base_cap_r <= 1'b0;
      win_hit_r <= 1'b0;
    end else begin
      if (!base_cap_r) begin
        base_r <= ~addr_jumper_on;
        base_cap_r <= 1'b1;
      end
      // Bases below 100 hex are outside the selectable range and never decode.
      win_hit_r <= base_cap_r && base_r[4:3] != cdio_pkg::BASE_LOW_FORBID
                   && host_io_addr[9:cdio_pkg::WIN_LSB] == base_r;
    end
  end

  assign host_win_hit = win_hit_r;

endmodule // cdio_top

//--- design/cdio_pkg.sv
// Constants shared by the digital I/O block: register map, field layout,
// reset values and decode figures.
// Assumes a 32-bit APB master and one clock, pclk.
package cdio_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int NUM_UNITS = 2;
  localparam int PORTS_PER_UNIT = 3;
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int UNIT_W = 24;
  localparam int LINES = 48;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_UNIT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_FIRST = 8'h00;
  localparam logic [7:0] OFS_SECOND = 8'h04;
  localparam logic [7:0] OFS_THIRD = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_ST = 8'h24;
  localparam logic [7:0] OFS_BUF = 8'h28;
  localparam logic [7:0] OFS_IRQ_LVL = 8'h2C;
  localparam logic [7:0] OFS_BASE = 8'h30;

  // ------------------------------------------------------------------
  // Fields: direction control (1 = input)
  // ------------------------------------------------------------------
  localparam int CTRL_W = 4;
  localparam int CTRL_FIRST_IN = 0;
  localparam int CTRL_SECOND_IN = 1;
  localparam int CTRL_THIRD_LO_IN = 2;
  localparam int CTRL_THIRD_HI_IN = 3;
  localparam logic [3:0] CTRL_RST = 4'hF;

  // Buffer register: bit 0 program-control flag, bits 1..2 unit enables.
  localparam int BUF_PROG = 0;
  localparam int BUF_EN0 = 1;
  localparam logic [2:0] BUF_RST = 3'h0;

  localparam logic [5:0] IRQ_EN_RST = 6'h00;
  localparam logic [3:0] IRQ_LVL_RST = 4'h3;
  localparam logic [7:0] LATCH_RST = 8'h00;

  // ------------------------------------------------------------------
  // Host I/O window decode
  // ------------------------------------------------------------------
  localparam int WIN_LSB = 5;
  localparam logic [1:0] BASE_LOW_FORBID = 2'h0;
  localparam logic [15:0] IRQ_LEGAL = 16'hDEF8;

endpackage

//--- design/cdio_unit.sv
// One parallel interface unit: three byte ports, direction control,
// output latches, buffer enables and per-port change detection.
// Assumes pin inputs synchronous to clk; writes come as one-cycle strobes.
module cdio_unit (
  input wire logic clk,                     // Clock.
  input wire logic rst_n,                   // Asynchronous reset, active low.
  input wire logic wr_en,                   // Write strobe, one cycle.
  input wire logic [1:0] wr_sel,            // 0..2 port latch, 3 control.
  input wire logic [7:0] wdata,             // Write data.
  input wire logic buf_on,                  // Line buffers enabled.
  input wire logic [23:0] pin_in,           // Line levels.
  output logic [23:0] pin_out,              // Output latch values.
  output logic [23:0] pin_oe_n,             // Driver enable, low drives.
  output logic [23:0] port_rd,              // Port read values.
  output logic [3:0] ctrl_rd,               // Direction control.
  output logic [2:0] chg                    // Change seen per port.
);

  logic [3:0] ctrl_r;
  logic [23:0] latch_r;
  logic [23:0] prev_r;
  logic [23:0] oe_n_r;
  logic [23:0] in_mask;

  // --------------------------------------------------------------
  // Direction mask
  // --------------------------------------------------------------
  // The third port splits into two nibbles with their own direction.
  assign in_mask = {{4{ctrl_r[cdio_pkg::CTRL_THIRD_HI_IN]}},
                    {4{ctrl_r[cdio_pkg::CTRL_THIRD_LO_IN]}},
                    {8{ctrl_r[cdio_pkg::CTRL_SECOND_IN]}},
                    {8{ctrl_r[cdio_pkg::CTRL_FIRST_IN]}}};

  // Input bits show the line, output bits show the latch.
  assign port_rd = (pin_in & in_mask) | (latch_r & ~in_mask);
  assign ctrl_rd = ctrl_r;
  assign pin_out = latch_r;
  assign pin_oe_n = oe_n_r;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_port
      // Only bits configured as inputs can report a change.
      assign chg[g] = |((pin_in[g*8 +: 8] ^ prev_r[g*8 +: 8]) & in_mask[g*8 +: 8]);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          latch_r[g*8 +: 8] <= cdio_pkg::LATCH_RST;
        end else if (wr_en && wr_sel == 2'(g)) begin
          latch_r[g*8 +: 8] <= wdata;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Control, sample history and buffer direction
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= cdio_pkg::CTRL_RST;
      // History starts at the pulled-up idle level, so no false change follows reset.
      prev_r <= '1;
      oe_n_r <= '1;
    end else begin
      if (wr_en && wr_sel == 2'h3) begin
        ctrl_r <= wdata[3:0];
      end
      prev_r <= pin_in;
      oe_n_r <= in_mask | {24{~buf_on}};
    end
  end

endmodule // cdio_unit

//--- test/cdio_field.sv
// Field-side model of the 48 lines: pull-ups plus switchable drivers.
// Assumes the block's driver enables are active low.
module cdio_field (
  input wire logic [47:0] io_out,   // Block drive values.
  input wire logic [47:0] io_oe_n,  // Block driver enables, low drives.
  input wire logic [47:0] fld_en,   // Field drives the line.
  input wire logic [47:0] fld_val,  // Field drive level.
  output logic [47:0] io_in         // Resolved line level.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A line driven by nobody floats to its pull-up.
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & fld_en & fld_val) | (io_oe_n & ~fld_en);
endmodule // cdio_field

//--- test/cdio_monitor.sv
// Port-level assertions for the digital I/O block.
// Assumes it is bound to cdio_top, one clock pclk.
module cdio_monitor (
  input wire logic pclk,                 // Clock.
  input wire logic presetn,              // Reset, active low.
  input wire logic psel,                 // APB select.
  input wire logic penable,              // APB enable.
  input wire logic pwrite,               // APB direction.
  input wire logic pready,               // APB ready.
  input wire logic pslverr,              // APB error.
  input wire logic [47:0] io_in,         // Line levels.
  input wire logic [47:0] io_out,        // Line drive values.
  input wire logic [47:0] io_oe_n,       // Driver enables.
  input wire logic [9:0] host_io_addr,   // Host address.
  input wire logic host_win_hit,         // Window hit.
  input wire logic irq,                  // Interrupt.
  input wire logic [15:0] host_irq_lines // Routed levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_acc = psel && penable && pwrite;
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_irq_holds: assert property (irq && !wr_acc |=> irq) else $error("interrupt dropped without write");
  a_irq_cause: assert property ($rose(irq) |-> io_in != $past(io_in) || $past(io_in) != $past(io_in, 2) ||
    $past(io_in, 2) != $past(io_in, 3)) else $error("interrupt without line change");
  a_level_onehot: assert property (irq |-> $onehot(host_irq_lines) &&
    (host_irq_lines & ~cdio_pkg::IRQ_LEGAL) == 16'h0000) else $error("bad routed level");
  a_lines_quiet: assert property (!irq |-> host_irq_lines == 16'h0000) else $error("level without irq");
  a_out_by_write: assert property (!$stable(io_out) |-> $past(wr_acc)) else $error("latch moved alone");
  a_oe_by_write: assert property (!$stable(io_oe_n) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("direction moved alone");
  a_hit_range: assert property (host_win_hit |-> $past(host_io_addr[9:8]) != 2'h0) else $error("hit low");
endmodule // cdio_monitor
bind cdio_top cdio_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .io_in,
  .io_out, .io_oe_n, .host_io_addr, .host_win_hit, .irq, .host_irq_lines);

//--- test/tb_top.sv
// Self-checking bench: APB registers, line directions, change interrupt,
// level routing and host window decode.
// Assumes cdio_top, cdio_field and the bound monitor are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_win_hit, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [47:0] io_in, io_out, io_oe_n, fld_en, fld_val;
  logic [4:0] addr_jumper_on;
  logic [9:0] host_io_addr;
  logic [15:0] host_irq_lines;
  logic [3:0] lvl;
  logic [39:0] wa;
  logic [32:0] exp_q[$];
  int err_count, checks_done, cyc, seed;
  cdio_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_in,
    .io_out, .io_oe_n, .addr_jumper_on, .host_io_addr, .host_win_hit, .irq, .host_irq_lines);
  cdio_field fld (.io_out, .io_oe_n, .fld_en, .fld_val, .io_in);
  // ----------------------------------------------------------------
  // Clock, checking and bus tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  // Lets registered outputs that follow a write settle.
  task automatic look;
    repeat (2) @(negedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) cmp({15'h0, pslverr, pwrite ? 32'h0 : prdata}, {15'h0, exp_q.pop_front()});
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    seed = 32'h04b67759;
    {psel, penable, pwrite, paddr, pwdata, fld_en, host_io_addr} = '0;
    fld_val = '1;
    presetn = 1'b0;
    addr_jumper_on = 5'h06;
    wa = {10'h31F, 10'h320, 10'h33F, 10'h340};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0C, 32'hF);
    rd(8'h1C, 32'hF);
    rd(8'h2C, 32'h3);
    rd(8'h30, {27'h0, ~addr_jumper_on});
    apb(1'b0, 8'h34, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h34, 32'hFFFF_FFFF, {1'b1, 32'h0});
    $display("test done: reset values");
    rv = $random(seed);
    wr(8'h00, rv);
    wr(8'h0C, 32'h2);
    fld_en[15:8] <= 8'hFF;
    fld_val[15:8] <= rv[15:8];
    rd(8'h00, {24'h0, rv[7:0]});
    rd(8'h04, {24'h0, rv[15:8]});
    look();
    cmp(io_out[7:0], rv[7:0]);
    cmp(io_oe_n, {24'hFFFFFF, 24'h00FF00});
    for (int i = 2; i < 4; i++) begin
      wr(8'h0C, 32'h1 << i);
      look();
      cmp(io_oe_n[23:0], 24'h0F0000 << ((i - 2) * 4));
    end
    wr(8'h28, 32'h1);
    look();
    cmp(io_oe_n, {48{1'b1}});
    wr(8'h28, 32'h3);
    look();
    cmp(io_oe_n[23:0], 24'hF00000);
    wr(8'h28, 32'h0);
    $display("test done: directions and buffers");
    wr(8'h20, 32'h8);
    fld_en[47] <= 1'b1;
    fld_val[47] <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    cmp(irq, 1'b0);
    @(posedge pclk);
    fld_en[26] <= 1'b1;
    fld_val[26] <= 1'b0;
    for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge pclk);
    look();
    cmp(irq, 1'b1);
    rd(8'h24, 32'h8);
    lvl = 4'h3;
    for (int l = 0; l < 16; l++) begin
      wr(8'h2C, l);
      if (cdio_pkg::IRQ_LEGAL[l]) lvl = l[3:0];
      rd(8'h2C, {28'h0, lvl});
      cmp(host_irq_lines, 16'h1 << lvl);
    end
    wr(8'h24, 32'h8);
    look();
    cmp({irq, host_irq_lines}, 17'h0);
    wr(8'h14, rv);
    wr(8'h1C, 32'h0);
    look();
    cmp({io_out[47:24], io_oe_n[47:24]}, {8'h00, rv[7:0], 8'h00, 24'h000000});
    cmp(irq, 1'b0);
    $display("test done: change interrupt");
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      host_io_addr <= (i == 4) ? 10'($random(seed)) : wa[i*10 +: 10];
      look();
      cmp(host_win_hit, host_io_addr[9:5] == ~addr_jumper_on);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    addr_jumper_on <= 5'h1F;
    host_io_addr <= 10'h010;
    look();
    cmp(io_oe_n, {48{1'b1}});
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    cmp(host_win_hit, 1'b0);
    rd(8'h30, 32'h0);
    $display("test done: window and second reset");
    end_sim();
  end
endmodule // tb_top
